// ### src/pbo_port_b_override.sv
// Port B alternate-function override logic, registered pad controls
//
// Overview of operation
// - Three-wire mode leaves pin 0 direction and pull-up untouched; value too unless PWM A is on.
// - Two-wire mode makes pin 0 open-collector data, driving only when output.
// - Two-wire pin 0 pulls low if output bit or shift bit is zero.
// - Two-wire mode forces pull-ups off on data and clock pins.
// - Unless two-wire mode owns it as output, pin 0 may drive inverted PWM channel A.
// - Pin-change enable needs global enable, group enable and no masking.
// - Pin 0 masking: inverted PWM A and serial data input, both modes.
// - Unmasked enabled pin-change keeps input buffer on during sleep.
// - Upper group pin-change needs global flag, group bit, no alt function.
// - Pins 4 and 5 lose pull-up and direction to zero when fused off.
// - Pin 4 input forced on while external clock source is selected.
// - Level interrupt on pin 6 needs global and mask; forces input on.
// - Pin 2 value is PWM B, suppressed in two-wire with output set.
// - Pin 1 value carries serial out in three-wire, else gated PWM A.
// - Pin 3 drives PWM B when enabled; input override needs pin-change.
// - Pin 2 input override: free pin-change or start interrupt enabled.
// - Two-wire clock pin pulls low on zero output bit or start hold.
// - Reset pin use forces pull-up on, driver off, input off.
`timescale 1ns/100ps
`default_nettype none

module pbo_port_b_override
    import pbo_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire pbo_ctrl_t ctrl,
    input wire pbo_port_t port,
    input wire logic sleeping,
    output pbo_pad_t pad_q,
    output logic [7:0] pin_change_armed_q,
    output logic ext_level_irq_enable_q,
    output logic counter_clock_input_q
);

    // =========================================================================
    // Shared enable terms
    logic low_grp_en;
    logic high_grp_en;
    logic ext_level_irq;
    logic two_wire;
    logic three_wire;
    logic serial_any;
    logic reset_pin_used;
    logic dir0;
    logic dir2;
    logic tw_data_owned;
    logic tw_clk_owned;

    assign low_grp_en = ctrl.global_irq_enable &
        ctrl.low_group_change_enable;
    assign high_grp_en = ctrl.global_irq_enable &
        ctrl.high_group_change_enable;
    assign ext_level_irq = ctrl.global_irq_enable &
        ctrl.ext_level_irq_mask;
    assign two_wire = ctrl.serial_two_wire;
    assign three_wire = ctrl.serial_three_wire;
    assign serial_any = two_wire | three_wire;
    // Fuse is active low: unprogrammed keeps the pin as the reset input
    assign reset_pin_used = ctrl.reset_pin_disable_fuse;
    assign dir0 = port.direction_bits[PBO_PIN_DATA];
    assign dir2 = port.direction_bits[PBO_PIN_SCLK];
    assign tw_data_owned = two_wire & dir0;
    assign tw_clk_owned = two_wire & dir2;

    // =========================================================================
    // Alternate functions that mask pin-change, one term per pin
    logic [7:0] change_mask;

    // Armed means group enabled and no alternate function masking the pin
    function automatic logic change_armed(input logic grp_en,
                                          input logic masked);
        return grp_en & ~masked;
    endfunction : change_armed

    // The mask vector feeds the arming of every pin but the sleep input buffers only of pins 0 to 2;
    // pins 3 to 7 repeat its terms in their own input enables, pin 6 without the level interrupt term
    always_comb
    begin
        change_mask = PBO_RST_BYTE;
        // Serial data in either mode, or inverted PWM A
        change_mask[PBO_PIN_DATA] = serial_any | ctrl.pwm_chan_a_enable;
        // Three-wire data out or PWM A
        change_mask[PBO_PIN_DOUT] = three_wire | ctrl.pwm_chan_a_enable;
        // Serial clock in either mode, or PWM B
        change_mask[PBO_PIN_SCLK] = serial_any | ctrl.pwm_chan_b_enable;
        change_mask[PBO_PIN_CMPB] = ctrl.pwm_chan_b_enable;
        // Crystal pins mask while the fuses take them from the port
        change_mask[PBO_PIN_XIN] = ~ctrl.pin4_io_allowed;
        change_mask[PBO_PIN_XOUT] = ~ctrl.pin5_io_allowed;
        // Level interrupt and counter clock both own pin 6
        change_mask[PBO_PIN_LVL] = ext_level_irq |
            ctrl.counter_ext_clock_pin;
        change_mask[PBO_PIN_RST] = reset_pin_used;
    end

    // =========================================================================
    // Override sets, one per pin
    pbo_ovr_t ovr [PBO_NPINS];

    // Open-collector: value stays low, direction decides whether we pull
    function automatic pbo_ovr_t open_drain(input logic active,
                                            input logic pull_low);
        pbo_ovr_t o;
        o = '0;
        o.pullup_override_enable = active;
        o.direction_override_enable = active;
        o.direction_override_value = pull_low;
        return o;
    endfunction : open_drain

    // Pin 0: data line, inverted PWM A
    always_comb
    begin
        ovr[PBO_PIN_DATA] = open_drain(two_wire,
            (~ctrl.serial_shift_out |
             ~port.output_bits[PBO_PIN_DATA]) & dir0);
        // Three-wire mode adds nothing here: pin keeps its port direction
        ovr[PBO_PIN_DATA].value_override_enable =
            tw_data_owned | ctrl.pwm_chan_a_enable;
        ovr[PBO_PIN_DATA].value_override_value = ~tw_data_owned &
            ctrl.pwm_chan_a_enable & ~ctrl.pwm_chan_a_out;
        ovr[PBO_PIN_DATA].input_enable_override_enable =
            change_armed(low_grp_en, change_mask[PBO_PIN_DATA]) |
            ctrl.start_condition_irq_enable;
        ovr[PBO_PIN_DATA].input_enable_override_value = 1'b1;
    end

    // Pin 1: serial data out or PWM A
    always_comb
    begin
        ovr[PBO_PIN_DOUT] = '0;
        ovr[PBO_PIN_DOUT].value_override_enable =
            three_wire | ctrl.pwm_chan_a_enable;
        ovr[PBO_PIN_DOUT].value_override_value =
            three_wire ? ctrl.serial_shift_out
            : (ctrl.pwm_chan_a_enable & ctrl.pwm_chan_a_out);
        ovr[PBO_PIN_DOUT].input_enable_override_enable =
            change_armed(low_grp_en, change_mask[PBO_PIN_DOUT]);
        ovr[PBO_PIN_DOUT].input_enable_override_value = 1'b1;
    end

    // Pin 2: serial clock, PWM B
    always_comb
    begin
        ovr[PBO_PIN_SCLK] = open_drain(two_wire,
            (ctrl.start_clock_hold |
             ~port.output_bits[PBO_PIN_SCLK]) & dir2);
        ovr[PBO_PIN_SCLK].value_override_enable =
            tw_clk_owned | ctrl.pwm_chan_b_enable;
        ovr[PBO_PIN_SCLK].value_override_value =
            ~tw_clk_owned & ctrl.pwm_chan_b_out;
        ovr[PBO_PIN_SCLK].input_enable_override_enable =
            change_armed(low_grp_en, change_mask[PBO_PIN_SCLK]) |
            ctrl.start_condition_irq_enable;
        ovr[PBO_PIN_SCLK].input_enable_override_value = 1'b1;
    end

    // Pin 3: PWM B
    always_comb
    begin
        ovr[PBO_PIN_CMPB] = '0;
        ovr[PBO_PIN_CMPB].value_override_enable =
            ctrl.pwm_chan_b_enable;
        ovr[PBO_PIN_CMPB].value_override_value = ctrl.pwm_chan_b_out;
        ovr[PBO_PIN_CMPB].input_enable_override_enable =
            low_grp_en & ~ctrl.pwm_chan_b_enable;
        ovr[PBO_PIN_CMPB].input_enable_override_value = 1'b1;
    end

    // Pin 4: crystal input, external clock
    always_comb
    begin
        ovr[PBO_PIN_XIN] = '0;
        ovr[PBO_PIN_XIN].pullup_override_enable =
            ~ctrl.pin4_io_allowed;
        ovr[PBO_PIN_XIN].direction_override_enable =
            ~ctrl.pin4_io_allowed;
        ovr[PBO_PIN_XIN].input_enable_override_enable = high_grp_en |
            ~ctrl.pin4_io_allowed | ctrl.ext_clock_selected;
        ovr[PBO_PIN_XIN].input_enable_override_value =
            (high_grp_en & ctrl.pin4_io_allowed) |
            ctrl.ext_clock_selected;
    end

    // Pin 5: crystal output
    always_comb
    begin
        ovr[PBO_PIN_XOUT] = '0;
        ovr[PBO_PIN_XOUT].pullup_override_enable =
            ~ctrl.pin5_io_allowed;
        ovr[PBO_PIN_XOUT].direction_override_enable =
            ~ctrl.pin5_io_allowed;
        ovr[PBO_PIN_XOUT].input_enable_override_enable =
            high_grp_en | ~ctrl.pin5_io_allowed;
        ovr[PBO_PIN_XOUT].input_enable_override_value =
            high_grp_en & ctrl.pin5_io_allowed;
    end

    // Pin 6: level interrupt, counter clock
    always_comb
    begin
        ovr[PBO_PIN_LVL] = '0;
        ovr[PBO_PIN_LVL].input_enable_override_enable =
            (~ctrl.counter_ext_clock_pin & high_grp_en) |
            ext_level_irq;
        ovr[PBO_PIN_LVL].input_enable_override_value = 1'b1;
    end

    // Pin 7: external reset
    always_comb
    begin
        ovr[PBO_PIN_RST] = '0;
        ovr[PBO_PIN_RST].pullup_override_enable = reset_pin_used;
        ovr[PBO_PIN_RST].pullup_override_value = 1'b1;
        ovr[PBO_PIN_RST].direction_override_enable = reset_pin_used;
        ovr[PBO_PIN_RST].input_enable_override_enable =
            high_grp_en | reset_pin_used;
        ovr[PBO_PIN_RST].input_enable_override_value =
            high_grp_en & ~reset_pin_used;
    end

    // =========================================================================
    // Pin-change arming, masked per pin by alternate functions
    logic [7:0] armed_d;

    always_comb
    begin
        armed_d = PBO_RST_BYTE;
        armed_d[PBO_PIN_DATA] = change_armed(low_grp_en,
            change_mask[PBO_PIN_DATA]);
        armed_d[PBO_PIN_DOUT] = change_armed(low_grp_en,
            change_mask[PBO_PIN_DOUT]);
        armed_d[PBO_PIN_SCLK] = change_armed(low_grp_en,
            change_mask[PBO_PIN_SCLK]);
        armed_d[PBO_PIN_CMPB] = change_armed(low_grp_en,
            change_mask[PBO_PIN_CMPB]);
        // Upper group: the pin's own alternate function must be idle
        armed_d[PBO_PIN_XIN] = change_armed(high_grp_en,
            change_mask[PBO_PIN_XIN]);
        armed_d[PBO_PIN_XOUT] = change_armed(high_grp_en,
            change_mask[PBO_PIN_XOUT]);
        armed_d[PBO_PIN_LVL] = change_armed(high_grp_en,
            change_mask[PBO_PIN_LVL]);
        armed_d[PBO_PIN_RST] = change_armed(high_grp_en,
            change_mask[PBO_PIN_RST]);
    end

    // =========================================================================
    // Resolution against port registers
    pbo_pad_t pad_d;

    for (genvar i = 0; i < PBO_NPINS; i++)
    begin : g_pin
        pbo_resolve u_resolve (
            .ovr(ovr[i]),
            .port_out(port.output_bits[i]),
            .port_dir(port.direction_bits[i]),
            .sleeping(sleeping),
            .pullup_on(pad_d.pullup_on[i]),
            .drive_oe(pad_d.drive_oe[i]),
            .drive_out(pad_d.drive_out[i]),
            .input_on(pad_d.input_on[i])
        );
    end

    // =========================================================================
    // Output registers: pads released and inputs off while in reset
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            pad_q <= '0;
        else
            pad_q <= pad_d;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            pin_change_armed_q <= PBO_RST_BYTE;
        else
            pin_change_armed_q <= armed_d;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            ext_level_irq_enable_q <= PBO_RST_BIT;
        else
            ext_level_irq_enable_q <= ext_level_irq;
    end

    // Counter clock sampling path only meaningful when its input is on
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            counter_clock_input_q <= PBO_RST_BIT;
        else
            counter_clock_input_q <= ctrl.counter_ext_clock_pin &
                pad_d.input_on[PBO_PIN_LVL];
    end

endmodule : pbo_port_b_override

`default_nettype wire

// ### src/pbo_pkg.sv
// Package for the port B alternate-function override block
package pbo_pkg;

    // =========================================================================
    // Widths and pin indices
    localparam int PBO_NPINS = 8;
    localparam int PBO_PIN_DATA = 0;
    localparam int PBO_PIN_DOUT = 1;
    localparam int PBO_PIN_SCLK = 2;
    localparam int PBO_PIN_CMPB = 3;
    localparam int PBO_PIN_XIN = 4;
    localparam int PBO_PIN_XOUT = 5;
    localparam int PBO_PIN_LVL = 6;
    localparam int PBO_PIN_RST = 7;

    // =========================================================================
    // Reset values of the registered outputs
    localparam logic [7:0] PBO_RST_BYTE = 8'h00;
    localparam logic PBO_RST_BIT = 1'b0;

    // =========================================================================
    // Override set for one pin
    typedef struct packed {
        logic pullup_override_enable;
        logic pullup_override_value;
        logic direction_override_enable;
        logic direction_override_value;
        logic value_override_enable;
        logic value_override_value;
        logic input_enable_override_enable;
        logic input_enable_override_value;
    } pbo_ovr_t;

    // Peripheral and fuse controls feeding the override logic
    typedef struct packed {
        logic global_irq_enable;
        logic low_group_change_enable;
        logic high_group_change_enable;
        logic ext_level_irq_mask;
        logic serial_two_wire;
        logic serial_three_wire;
        logic serial_shift_out;
        logic start_clock_hold;
        logic start_condition_irq_enable;
        logic pwm_chan_a_enable;
        logic pwm_chan_a_out;
        logic pwm_chan_b_enable;
        logic pwm_chan_b_out;
        logic counter_ext_clock_pin;
        logic reset_pin_disable_fuse;
        logic pin4_io_allowed;
        logic pin5_io_allowed;
        logic ext_clock_selected;
    } pbo_ctrl_t;

    // Port register view
    typedef struct packed {
        logic [7:0] output_bits;
        logic [7:0] direction_bits;
    } pbo_port_t;

    // Final pad controls
    typedef struct packed {
        logic [7:0] pullup_on;
        logic [7:0] drive_oe;
        logic [7:0] drive_out;
        logic [7:0] input_on;
    } pbo_pad_t;

endpackage : pbo_pkg

// ### src/pbo_resolve.sv
// Per-pin resolution of an override set against the port registers
`timescale 1ns/100ps
`default_nettype none

module pbo_resolve
    import pbo_pkg::*;
(
    input wire pbo_ovr_t ovr,
    input wire logic port_out,
    input wire logic port_dir,
    input wire logic sleeping,
    output logic pullup_on,
    output logic drive_oe,
    output logic drive_out,
    output logic input_on
);

    // =========================================================================
    // Override mux
    logic dir_eff;
    logic val_eff;
    logic pu_req;

    assign dir_eff = ovr.direction_override_enable ?
        ovr.direction_override_value : port_dir;
    assign val_eff = ovr.value_override_enable ?
        ovr.value_override_value : port_out;
    // Pull-up request follows the usual input-and-output-bit-high convention
    assign pu_req = ~port_dir & port_out;
    assign pullup_on = ovr.pullup_override_enable ?
        ovr.pullup_override_value : pu_req;
    assign drive_oe = dir_eff;
    assign drive_out = val_eff;
    // Awake: input buffer on unless overridden; asleep: only when overridden
    assign input_on = ovr.input_enable_override_enable ?
        ovr.input_enable_override_value : ~sleeping;

endmodule : pbo_resolve

`default_nettype wire

// ### verification/pbo_port_b_override_props.sv
// Concurrent checks on the ports of the port B override block
`timescale 1ns/100ps
`default_nettype none

module pbo_port_b_override_props
    import pbo_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire pbo_ctrl_t ctrl,
    input wire pbo_port_t port,
    input wire logic sleeping,
    input wire pbo_pad_t pad_q,
    input wire logic [7:0] pin_change_armed_q,
    input wire logic ext_level_irq_enable_q,
    input wire logic counter_clock_input_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // ========================================================================
    // Each pad control follows its causes one edge later
    AST_TW_PULLUP: assert property (
        ctrl.serial_two_wire |=> !pad_q.pullup_on[0] && !pad_q.pullup_on[2])
        else $error("pull-up left on in two-wire mode");
    AST_TW_DATA_LOW: assert property (
        ctrl.serial_two_wire && port.direction_bits[0] &&
        (!port.output_bits[0] || !ctrl.serial_shift_out)
        |=> pad_q.drive_oe[0] && !pad_q.drive_out[0])
        else $error("data line not pulled low");
    AST_TW_CLOCK_LOW: assert property (
        ctrl.serial_two_wire && port.direction_bits[2] &&
        (!port.output_bits[2] || ctrl.start_clock_hold)
        |=> pad_q.drive_oe[2] && !pad_q.drive_out[2])
        else $error("clock line not pulled low");
    AST_THREE_WIRE_KEEP: assert property (
        ctrl.serial_three_wire && !ctrl.serial_two_wire &&
        !ctrl.pwm_chan_a_enable
        |=> pad_q.drive_oe[0] == $past(port.direction_bits[0]) &&
        pad_q.pullup_on[0] == (!$past(port.direction_bits[0]) &&
        $past(port.output_bits[0])))
        else $error("three-wire mode altered pin 0");
    AST_PWM_A_INV: assert property (
        !ctrl.serial_two_wire && !ctrl.serial_three_wire &&
        ctrl.pwm_chan_a_enable
        |=> pad_q.drive_out[0] == !$past(ctrl.pwm_chan_a_out))
        else $error("pin 0 not inverted channel A");
    AST_GLOBAL_OFF: assert property (
        !ctrl.global_irq_enable |=> pin_change_armed_q == 8'h00)
        else $error("pin change armed without global enable");
    AST_PIN0_MASK: assert property (
        ctrl.pwm_chan_a_enable || ctrl.serial_two_wire ||
        ctrl.serial_three_wire |=> !pin_change_armed_q[0])
        else $error("pin 0 change not masked");
    AST_XTAL_PINS: assert property (
        !ctrl.pin4_io_allowed |=> !pad_q.pullup_on[4] && !pad_q.drive_oe[4])
        else $error("pin 4 not taken from port");
    AST_EXT_CLOCK: assert property (
        ctrl.ext_clock_selected |=> pad_q.input_on[4])
        else $error("clock pin input off");
    AST_LEVEL_IRQ: assert property (
        ctrl.global_irq_enable && ctrl.ext_level_irq_mask
        |=> ext_level_irq_enable_q && pad_q.input_on[6])
        else $error("level interrupt not enabled");
    AST_RESET_PIN: assert property (
        ctrl.reset_pin_disable_fuse |=> pad_q.pullup_on[7] &&
        !pad_q.drive_oe[7] && !pad_q.input_on[7])
        else $error("reset pin controls wrong");
    AST_FALLBACK: assert property (
        1'b1 |=> pad_q.drive_oe[6] == $past(port.direction_bits[6]) &&
        pad_q.drive_out[6] == $past(port.output_bits[6]))
        else $error("pin 6 does not follow port");
endmodule : pbo_port_b_override_props

bind pbo_port_b_override pbo_port_b_override_props u_props (
    .clk(clk),
    .sys_rst(sys_rst),
    .ctrl(ctrl),
    .port(port),
    .sleeping(sleeping),
    .pad_q(pad_q),
    .pin_change_armed_q(pin_change_armed_q),
    .ext_level_irq_enable_q(ext_level_irq_enable_q),
    .counter_clock_input_q(counter_clock_input_q)
);
`default_nettype wire

// ### verification/pbo_pin_model.sv
// Pin-side model: resolves each pad to the level seen on the wire
`timescale 1ns/100ps
`default_nettype none

module pbo_pin_model
    import pbo_pkg::*;
(
    input wire logic clk,
    input wire pbo_pad_t pad,
    input wire logic [7:0] bus_pullup,
    output logic [7:0] level
);
    logic [7:0] last_q;

    // A floating pin shows its inverted last level, so a lost drive
    // cannot pass for the old value
    always_ff @(posedge clk)
    begin
        last_q <= level;
    end

    always_comb
    begin
        for (int i = 0; i < PBO_NPINS; i++)
        begin
            if (pad.drive_oe[i])
                level[i] = pad.drive_out[i];
            else if (pad.pullup_on[i] || bus_pullup[i])
                level[i] = 1'b1;
            else
                level[i] = ~last_q[i];
        end
    end
endmodule : pbo_pin_model
`default_nettype wire

// ### verification/testbench.sv
// Self-checking testbench for the port B override block
`timescale 1ns/100ps
`default_nettype none

module testbench
    import pbo_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic sleeping = 1'b0;
    pbo_ctrl_t ctrl = '0;
    pbo_port_t port = '0;
    pbo_pad_t pad_q;
    logic [7:0] armed;
    logic [7:0] level;
    logic lvl_irq;
    logic cnt_in;
    int miscompares = 0;
    int check_count = 0;

    always #5 clk = ~clk;

    pbo_port_b_override DUT (.clk(clk), .sys_rst(sys_rst), .ctrl(ctrl),
        .port(port), .sleeping(sleeping), .pad_q(pad_q),
        .pin_change_armed_q(armed), .ext_level_irq_enable_q(lvl_irq),
        .counter_clock_input_q(cnt_in));
    // Serial bus lines carry an external pull-up
    pbo_pin_model u_pins (.clk(clk), .pad(pad_q), .bus_pullup(8'h05),
        .level(level));

    // ========================================================================
    // Shared tasks
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask : chk

    // One edge to launch, one edge of latency, then look
    task apply(input pbo_ctrl_t c, input pbo_port_t p, input logic s);
        @(posedge clk);
        ctrl <= c;
        port <= p;
        sleeping <= s;
        @(posedge clk);
        #1;
    endtask : apply

    task end_sim();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    // ========================================================================
    // Scenarios
    task t_two_wire();
        pbo_ctrl_t c;
        for (int k = 0; k < 4; k++)
        begin
            c = '0;
            c.serial_two_wire = 1'b1;
            c.serial_shift_out = k[0];
            c.start_clock_hold = k[1];
            apply(c, {5'h00, 1'b1, 1'b0, k[1], 8'h05}, 1'b0);
            chk("tw oe", {5'h00, k[1], 1'b0, !(k[1] & k[0])},
                pad_q.drive_oe & 8'h05);
            chk("tw out", 8'h00, pad_q.drive_out & 8'h05);
            chk("tw pull", 8'h00, pad_q.pullup_on & 8'h05);
            chk("tw sda", {7'h00, k[1] & k[0]}, level & 8'h01);
        end
        apply(c, {8'h00, 8'h00}, 1'b0);
        chk("tw input", 8'h00, pad_q.drive_oe & 8'h05);
        $display("two-wire test done");
    endtask : t_two_wire

    task t_three_wire();
        pbo_ctrl_t c;
        c = '0;
        c.serial_three_wire = 1'b1;
        c.serial_shift_out = 1'b1;
        c.global_irq_enable = 1'b1;
        c.low_group_change_enable = 1'b1;
        apply(c, {8'h01, 8'h02}, 1'b0);
        chk("3w pull", 8'h01, pad_q.pullup_on & 8'h01);
        chk("3w oe", 8'h02, pad_q.drive_oe & 8'h03);
        chk("3w out", 8'h02, pad_q.drive_out & 8'h02);
        chk("3w armed", 8'h08, armed & 8'h09);
        $display("three-wire test done");
    endtask : t_three_wire

    task t_pwm();
        pbo_ctrl_t c;
        c = '0;
        c.pwm_chan_a_enable = 1'b1;
        c.pwm_chan_b_enable = 1'b1;
        for (int v = 0; v < 2; v++)
        begin
            c.pwm_chan_a_out = v[0];
            c.pwm_chan_b_out = v[0];
            apply(c, {8'h00, 8'h0f}, 1'b0);
            chk("pwm out", {4'h0, v[0], v[0], v[0], !v[0]},
                pad_q.drive_out & 8'h0f);
        end
        c.pwm_chan_a_enable = 1'b0;
        c.serial_two_wire = 1'b1;
        apply(c, {8'h05, 8'h0f}, 1'b0);
        chk("pwm gate", 8'h08, pad_q.drive_out & 8'h0f);
        $display("pwm test done");
    endtask : t_pwm

    task t_pin_change();
        pbo_ctrl_t c;
        c = '0;
        c.global_irq_enable = 1'b1;
        c.low_group_change_enable = 1'b1;
        c.high_group_change_enable = 1'b1;
        c.pin4_io_allowed = 1'b1;
        c.pin5_io_allowed = 1'b1;
        apply(c, '0, 1'b1);
        chk("armed all", 8'hff, armed);
        chk("sleep in", 8'hff, pad_q.input_on);
        c.high_group_change_enable = 1'b0;
        apply(c, '0, 1'b1);
        chk("armed low", 8'h0f, armed);
        chk("sleep low", 8'h0f, pad_q.input_on);
        c.global_irq_enable = 1'b0;
        apply(c, '0, 1'b1);
        chk("armed none", 8'h00, armed);
        chk("sleep none", 8'h00, pad_q.input_on);
        apply(c, '0, 1'b0);
        chk("awake in", 8'hff, pad_q.input_on);
        $display("pin change test done");
    endtask : t_pin_change

    task t_fuses_irq();
        pbo_ctrl_t c;
        c = '0;
        c.reset_pin_disable_fuse = 1'b1;
        c.ext_clock_selected = 1'b1;
        apply(c, {8'hff, 8'hff}, 1'b1);
        chk("fuse pull", 8'h80, pad_q.pullup_on);
        chk("fuse oe", 8'h4f, pad_q.drive_oe);
        chk("fuse in", 8'h10, pad_q.input_on);
        c = '0;
        c.pin4_io_allowed = 1'b1;
        c.pin5_io_allowed = 1'b1;
        c.global_irq_enable = 1'b1;
        c.ext_level_irq_mask = 1'b1;
        c.start_condition_irq_enable = 1'b1;
        c.counter_ext_clock_pin = 1'b1;
        apply(c, '0, 1'b1);
        chk("irq in", 8'h45, pad_q.input_on);
        chk("irq en", 8'h03, {6'h00, lvl_irq, cnt_in});
        c.ext_level_irq_mask = 1'b0;
        apply(c, '0, 1'b1);
        chk("irq off", 8'h00, {6'h00, lvl_irq, pad_q.input_on[6]});
        $display("fuse and interrupt test done");
    endtask : t_fuses_irq

    task t_reset();
        apply('0, {8'hff, 8'h0f}, 1'b0);
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        #1;
        chk("rst pad", 8'h00, pad_q.pullup_on | pad_q.drive_oe |
            pad_q.drive_out | pad_q.input_on);
        chk("rst armed", 8'h00, armed);
        @(posedge clk);
        sys_rst <= 1'b0;
        $display("reset test done");
    endtask : t_reset

    initial
    begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_two_wire();
        t_three_wire();
        t_pwm();
        t_pin_change();
        t_fuses_irq();
        t_reset();
        t_pin_change();
        end_sim();
    end

    // Watchdog: the run needs far fewer cycles than this
    initial
    begin
        repeat (2000) @(posedge clk);
        miscompares++;
        end_sim();
    end
endmodule : testbench
`default_nettype wire
